// ==== inc/fifo_ready_lane_pkg.sv ====
// Package: register map, field layout, resets and lane modes of the port config
package fifo_ready_lane_pkg;
   localparam int          REG_ADDR_W        = 4;
   localparam logic [3:0]  OFF_LEVELS        = 4'h0;
   localparam logic [3:0]  OFF_LANE_MODE     = 4'h4;
   localparam logic [3:0]  OFF_STATUS        = 4'h8;
   localparam logic [7:0]  LEVELS_RESET      = 8'h77;
   localparam logic [7:0]  LANE_MODE_RESET   = 8'h00;
   localparam int          TX_LEVEL_LSB      = 4;
   localparam int          RX_LEVEL_LSB      = 0;
   localparam int          LEVEL_W           = 4;
   localparam int          SPLIT_BIT         = 4;
   localparam int          HDR_OFF_BIT       = 2;
   localparam int          WIDTH_BIT         = 1;
   localparam int          ORDER_BIT         = 0;
   localparam logic [7:0]  LANE_MASK_FIRST   = 8'h17;
   localparam logic [7:0]  LANE_MASK_OTHER   = 8'h07;
   localparam int          LEVEL_STEP_BYTES  = 8;
   localparam int          COUNT_W           = 9;

   typedef enum logic [2:0] {
      LANES_SHARED32 = 3'b001,
      LANES_SHARED64 = 3'b010,
      LANES_SPLIT    = 3'b100
   } lane_mode_type;
endpackage : fifo_ready_lane_pkg

// ==== rtl/level_compare.sv ====
// Threshold comparator: count against 8 x (level + 1) bytes, registered
module level_compare
   import fifo_ready_lane_pkg::*;
#(
   parameter int COUNT_BITS = COUNT_W
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_reset_n,
   input  wire logic [LEVEL_W-1:0]    i_level,
   input  wire logic [COUNT_BITS-1:0] i_count,
   output logic                       o_reached
);
   typedef struct packed {
      logic reached;
   } cmp_state_type;

   cmp_state_type s_q;
   cmp_state_type s_d;

   // Bytes needed for a level code
   function automatic logic [COUNT_BITS-1:0] level_bytes(
      input logic [LEVEL_W-1:0] lvl
   );
      logic [COUNT_BITS-1:0] sum;
      sum = COUNT_BITS'(({1'b0, lvl} + 5'h01) * LEVEL_STEP_BYTES);
      return sum;
   endfunction : level_bytes

   always_comb begin
      s_d         = s_q;
      s_d.reached = (i_count >= level_bytes(i_level));
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_reached = s_q.reached;
endmodule : level_compare

// ==== rtl/fifo_ready_lane_config.sv ====
// Per-port ready thresholds and bus lane configuration registers
// Functional notes
// RULE1 - Tx ready when free >= 8x(level+1)
// RULE2 - Rx ready when fill >= 8x(level+1)
// RULE3 - Software never writes zero level codes
// RULE4 - Split bit only acts on first port
// RULE5 - Shared 32 lanes when split, width clear
// RULE6 - Shared 64 lanes when width set
// RULE7 - Split: rx low lanes, tx high lanes
// RULE8 - Header-ready-off: only fill threshold counts
// RULE9 - Width set uses 64 bits, else 32
// RULE10 - Software keeps split clear with width set
// RULE11 - Byte order bit set means big-endian
// RULE12 - Reserved bits read zero, writes ignored
module fifo_ready_lane_config
   import fifo_ready_lane_pkg::*;
#(
   parameter bit IS_FIRST_PORT = 1'b1,
   parameter int COUNT_BITS    = COUNT_W
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_reset_n,
   input  wire logic [REG_ADDR_W-1:0] i_addr,
   input  wire logic [7:0]            i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic      [7:0]            o_rdata,
   input  wire logic [COUNT_BITS-1:0] i_tx_free_bytes,
   input  wire logic [COUNT_BITS-1:0] i_rx_fill_bytes,
   input  wire logic                  i_rx_header_in_fifo,
   output logic                       o_tx_space_ready,
   output logic                       o_rx_data_ready,
   output logic      [2:0]            o_lane_mode,
   output logic                       o_bus_64bit,
   output logic                       o_big_endian,
   output logic                       o_lane_conflict
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] levels;
      logic [7:0] lane;
      logic [7:0] rdata;
      logic       hdr;
   } cfg_state_type;

   cfg_state_type s_q;
   cfg_state_type s_d;

   logic tx_reached;
   logic rx_reached;
   logic split_eff;
   logic width_eff;
   logic hdr_off;
   logic [7:0] lane_mask;
   lane_mode_type mode;

   // Reserved positions masked at write; split only on first port
   assign lane_mask = IS_FIRST_PORT ? LANE_MASK_FIRST : LANE_MASK_OTHER;

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.hdr = i_rx_header_in_fifo;
      if (i_wr && i_addr == OFF_LEVELS) begin
         s_d.levels = i_wdata;
      end
      if (i_wr && i_addr == OFF_LANE_MODE) begin
         s_d.lane = i_wdata & lane_mask; // see RULE12 see RULE4
      end
      s_d.rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            OFF_LEVELS:    s_d.rdata = s_q.levels;
            OFF_LANE_MODE: s_d.rdata = s_q.lane; // see RULE12
            OFF_STATUS:    s_d.rdata = {5'h00, o_lane_conflict,
                                        o_rx_data_ready,
                                        o_tx_space_ready};
            default:       s_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_q.levels <= LEVELS_RESET;
         s_q.lane   <= LANE_MODE_RESET;
         s_q.rdata  <= 8'h00;
         s_q.hdr    <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;

   // ---------------------------------------------------------------
   // Ready thresholds
   // ---------------------------------------------------------------
   level_compare #(
      .COUNT_BITS (COUNT_BITS)
   ) u_tx_cmp (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_level   (s_q.levels[TX_LEVEL_LSB +: LEVEL_W]),
      .i_count   (i_tx_free_bytes),
      .o_reached (tx_reached)
   );

   level_compare #(
      .COUNT_BITS (COUNT_BITS)
   ) u_rx_cmp (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_level   (s_q.levels[RX_LEVEL_LSB +: LEVEL_W]),
      .i_count   (i_rx_fill_bytes),
      .o_reached (rx_reached)
   );

   // Header path registered too, so both ready sources line up
   logic hdr_q;
   assign hdr_q = s_q.hdr;

   assign hdr_off          = s_q.lane[HDR_OFF_BIT];
   assign o_tx_space_ready = tx_reached; // see RULE1
   assign o_rx_data_ready  = rx_reached | (hdr_q & ~hdr_off); // see RULE2 see RULE8

   // ---------------------------------------------------------------
   // Lane selection
   // ---------------------------------------------------------------
   assign split_eff = s_q.lane[SPLIT_BIT];
   assign width_eff = s_q.lane[WIDTH_BIT];

   always_comb begin
      mode = LANES_SHARED32; // see RULE5
      case ({split_eff, width_eff})
         2'b00:   mode = LANES_SHARED32; // see RULE5
         2'b01:   mode = LANES_SHARED64; // see RULE6
         2'b10:   mode = LANES_SPLIT;    // see RULE7
         2'b11:   mode = LANES_SPLIT;    // see RULE10
         default: mode = LANES_SHARED32;
      endcase
   end

   assign o_lane_mode     = mode;
   assign o_bus_64bit     = width_eff & ~split_eff; // see RULE9
   assign o_big_endian    = s_q.lane[ORDER_BIT];    // see RULE11
   // Illegal software setting flagged, split still wins
   assign o_lane_conflict = split_eff & width_eff;  // see RULE10

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_tx_ready;
      @(posedge i_clk) disable iff (!i_reset_n)
      $past(i_reset_n) |-> o_tx_space_ready == ($past(i_tx_free_bytes) >=
         COUNT_BITS'(({1'b0, $past(s_q.levels[7:4])} + 5'h01) * 8));
   endproperty
   a_tx_ready: assert property (p_tx_ready) // see RULE1
      else $error("tx ready mismatch");

   property p_rx_ready;
      @(posedge i_clk) disable iff (!i_reset_n)
      $past(i_reset_n) && (!hdr_q || hdr_off) |->
         o_rx_data_ready == ($past(i_rx_fill_bytes)
         >= COUNT_BITS'(({1'b0, $past(s_q.levels[3:0])} + 5'h01) * 8));
   endproperty
   a_rx_ready: assert property (p_rx_ready) // see RULE2
      else $error("rx ready mismatch");

   property p_hdr_off;
      @(posedge i_clk) disable iff (!i_reset_n)
      hdr_off && !rx_reached |-> !o_rx_data_ready;
   endproperty
   a_hdr_off: assert property (p_hdr_off) // see RULE8
      else $error("header raised rx ready while disabled");

   property p_split_first;
      @(posedge i_clk) disable iff (!i_reset_n)
      !IS_FIRST_PORT |-> !split_eff && o_lane_mode != LANES_SPLIT;
   endproperty
   a_split_first: assert property (p_split_first) // see RULE4
      else $error("split active on other port");

   property p_shared32;
      @(posedge i_clk) disable iff (!i_reset_n)
      !split_eff && !width_eff |-> o_lane_mode == LANES_SHARED32;
   endproperty
   a_shared32: assert property (p_shared32) // see RULE5
      else $error("shared 32 lane mode wrong");

   property p_shared64;
      @(posedge i_clk) disable iff (!i_reset_n)
      !split_eff && width_eff |-> o_lane_mode == LANES_SHARED64 && o_bus_64bit;
   endproperty
   a_shared64: assert property (p_shared64) // see RULE6
      else $error("shared 64 lane mode wrong");

   property p_split;
      @(posedge i_clk) disable iff (!i_reset_n)
      split_eff |-> o_lane_mode == LANES_SPLIT && !o_bus_64bit;
   endproperty
   a_split: assert property (p_split) // see RULE7
      else $error("split lane mode wrong");

   property p_width;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_addr == OFF_LANE_MODE && !i_wdata[4] |=>
         o_bus_64bit == $past(i_wdata[1]);
   endproperty
   a_width: assert property (p_width) // see RULE9
      else $error("bus width not following write");

   property p_order;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_addr == OFF_LANE_MODE |=> o_big_endian == $past(i_wdata[0]);
   endproperty
   a_order: assert property (p_order) // see RULE11
      else $error("byte order not following write");

   property p_reserved;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_rd && i_addr == OFF_LANE_MODE |=> (o_rdata & ~lane_mask) == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved) // see RULE12
      else $error("reserved bits read nonzero");

   property p_readback;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_addr == OFF_LEVELS ##1 i_rd && i_addr == OFF_LEVELS |=>
         o_rdata == $past(i_wdata, 2);
   endproperty
   a_readback: assert property (p_readback)
      else $error("levels readback mismatch");

   property p_levels_write;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_addr == OFF_LEVELS |=> s_q.levels == $past(i_wdata);
   endproperty
   a_levels_write: assert property (p_levels_write) // see RULE1
      else $error("levels write lost");

   property p_lane_write;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_wr && i_addr == OFF_LANE_MODE |=> s_q.lane == ($past(i_wdata) & lane_mask);
   endproperty
   a_lane_write: assert property (p_lane_write) // see RULE12
      else $error("lane write not masked");

   property p_rdata_idle;
      @(posedge i_clk) disable iff (!i_reset_n)
      !i_rd |=> o_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not cleared");

   property p_levels_hold;
      @(posedge i_clk) disable iff (!i_reset_n)
      !(i_wr && i_addr == OFF_LEVELS) |=> $stable(s_q.levels);
   endproperty
   a_levels_hold: assert property (p_levels_hold) // see RULE1
      else $error("levels changed without write");

   property p_lane_hold;
      @(posedge i_clk) disable iff (!i_reset_n)
      !(i_wr && i_addr == OFF_LANE_MODE) |=> $stable(s_q.lane);
   endproperty
   a_lane_hold: assert property (p_lane_hold) // see RULE12
      else $error("lane mode changed without write");

   property p_status_read;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_rd && i_addr == OFF_STATUS |=> o_rdata == {5'h00,
         $past(o_lane_conflict), $past(o_rx_data_ready), $past(o_tx_space_ready)};
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read mismatch");

   property p_bus64;
      @(posedge i_clk) disable iff (!i_reset_n)
      o_bus_64bit |-> o_lane_mode == LANES_SHARED64;
   endproperty
   a_bus64: assert property (p_bus64) // see RULE9
      else $error("64 bit bus outside shared 64 mode");

   property p_mode_onehot;
      @(posedge i_clk) disable iff (!i_reset_n)
      $onehot(o_lane_mode);
   endproperty
   a_mode_onehot: assert property (p_mode_onehot) // see RULE5
      else $error("lane mode not one-hot");

   property p_order_hold;
      @(posedge i_clk) disable iff (!i_reset_n)
      !(i_wr && i_addr == OFF_LANE_MODE) |=> $stable(o_big_endian);
   endproperty
   a_order_hold: assert property (p_order_hold) // see RULE11
      else $error("byte order changed without write");

   property p_hdr_ready;
      @(posedge i_clk) disable iff (!i_reset_n)
      hdr_q && !hdr_off |-> o_rx_data_ready;
   endproperty
   a_hdr_ready: assert property (p_hdr_ready) // see RULE8
      else $error("header did not raise rx ready");

   property p_tx_below;
      @(posedge i_clk) disable iff (!i_reset_n)
      $past(i_tx_free_bytes) < COUNT_BITS'(LEVEL_STEP_BYTES) |-> !o_tx_space_ready;
   endproperty
   a_tx_below: assert property (p_tx_below) // see RULE1
      else $error("tx ready below smallest threshold");

   property p_unmapped_read;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_rd && i_addr != OFF_LEVELS && i_addr != OFF_LANE_MODE &&
         i_addr != OFF_STATUS |=> o_rdata == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) // see RULE12
      else $error("unmapped read nonzero");

   property p_other_no_split;
      @(posedge i_clk) disable iff (!i_reset_n)
      !IS_FIRST_PORT |-> !o_lane_conflict;
   endproperty
   a_other_no_split: assert property (p_other_no_split) // see RULE4
      else $error("conflict flagged on other port");

   property p_rx_below;
      @(posedge i_clk) disable iff (!i_reset_n)
      $past(i_rx_fill_bytes) < 9'h008 && !hdr_q |-> !o_rx_data_ready;
   endproperty
   a_rx_below: assert property (p_rx_below) // see RULE2
      else $error("rx ready below smallest threshold");

   c_split: cover property (@(posedge i_clk) o_lane_mode == LANES_SPLIT);
   c_shared64: cover property (@(posedge i_clk)
      o_lane_mode == LANES_SHARED64);
   c_hdr_ready: cover property (@(posedge i_clk)
      hdr_q && !rx_reached && o_rx_data_ready);
   c_tx_ready: cover property (@(posedge i_clk) $rose(o_tx_space_ready));
   c_hdr_off: cover property (@(posedge i_clk)
      hdr_q && hdr_off && !o_rx_data_ready);
endmodule : fifo_ready_lane_config

// ==== verification/fifo_side_model.sv ====
// Far-side model: FIFO occupancy as the bus processor reports it
module fifo_side_model
   import fifo_ready_lane_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_reset_n,
   input  wire logic               i_load,
   input  wire logic [COUNT_W-1:0] i_free,
   input  wire logic [COUNT_W-1:0] i_fill,
   input  wire logic               i_header,
   output logic      [COUNT_W-1:0] o_tx_free_bytes,
   output logic      [COUNT_W-1:0] o_rx_fill_bytes,
   output logic                    o_rx_header_in_fifo
);
   // Empty FIFOs after reset; counts move only when a transfer is loaded
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_tx_free_bytes     <= 9'h100;
         o_rx_fill_bytes     <= 9'h000;
         o_rx_header_in_fifo <= 1'b0;
      end else if (i_load) begin
         o_tx_free_bytes     <= i_free;
         o_rx_fill_bytes     <= i_fill;
         o_rx_header_in_fifo <= i_header;
      end
   end
endmodule : fifo_side_model

// ==== verification/fifo_ready_lane_config_tb_top.sv ====
// Testbench: register access, lane decode and ready thresholds
`define CHK_EQ(act, exp) begin checked++; if ((act) !== (exp)) begin \
   bad_count++; $display("ERROR t=%0t got %h exp %h", $time, act, exp); \
   end end
module fifo_ready_lane_config_tb_top
   import fifo_ready_lane_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset_n, wr_s, rd_s, load, hdr, hdr_q, tx_rdy, rx_rdy;
   logic b64, byte_order_sel, confl;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, rdata2, r1, r2, d;
   logic [8:0] free, fill, tx_free, rx_fill;
   logic [2:0] mode, mode2;
   logic [3:0] lt, lr;
   logic       off;
   int bad_count = 0;
   int checked = 0;

   fifo_side_model i_fifo_side_model (.i_clk(clk), .i_reset_n(reset_n),
      .i_load(load), .i_free(free), .i_fill(fill), .i_header(hdr),
      .o_tx_free_bytes(tx_free), .o_rx_fill_bytes(rx_fill),
      .o_rx_header_in_fifo(hdr_q));
   fifo_ready_lane_config i_fifo_ready_lane_config (.i_clk(clk),
      .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
      .i_rd(rd_s), .o_rdata(rdata), .i_tx_free_bytes(tx_free),
      .i_rx_fill_bytes(rx_fill), .i_rx_header_in_fifo(hdr_q),
      .o_tx_space_ready(tx_rdy), .o_rx_data_ready(rx_rdy),
      .o_lane_mode(mode), .o_bus_64bit(b64), .o_big_endian(byte_order_sel),
      .o_lane_conflict(confl));
   // Second port shares the bus; split bit must be dead there
   fifo_ready_lane_config #(.IS_FIRST_PORT(1'b0)) i_other_port (.i_clk(clk),
      .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
      .i_rd(rd_s), .o_rdata(rdata2), .i_tx_free_bytes(tx_free),
      .i_rx_fill_bytes(rx_fill), .i_rx_header_in_fifo(hdr_q),
      .o_tx_space_ready(), .o_rx_data_ready(), .o_lane_mode(mode2),
      .o_bus_64bit(), .o_big_endian(), .o_lane_conflict());

   function automatic logic [8:0] thr(input logic [3:0] lvl);
      return ({5'h00, lvl} + 9'h001) << 3;
   endfunction : thr
   function automatic logic [2:0] lanes(input logic [7:0] m);
      return m[4] ? 3'b100 : (m[1] ? 3'b010 : 3'b001);
   endfunction : lanes
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      r1 = rdata;
      r2 = rdata2;
   endtask : rd
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Whole run needs under 2000 cycles; ten times that means a hang
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end

   initial begin
      {reset_n, wr_s, rd_s, load, hdr, addr, wdata, free, fill} = '0;
      void'($urandom(77));
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      // ----------------------------------------
      // Reset values, read strobe, unmapped slot
      // ----------------------------------------
      rd(OFF_LEVELS);
      `CHK_EQ(r1, 8'h77)
      @(posedge clk);
      #1 `CHK_EQ(rdata, 8'h00)
      rd(OFF_LANE_MODE);
      `CHK_EQ(r1, 8'h00)
      wr(4'hc, 8'hff);
      rd(4'hc);
      `CHK_EQ(r1, 8'h00)
      rd(OFF_LEVELS);
      `CHK_EQ(r1, 8'h77)
      // ----------------------------------------
      // Lane modes; width set keeps split clear
      // ----------------------------------------
      for (int i = 0; i < 32; i++) begin
         d = {3'($urandom), 5'(i)};
         if (d[1]) d[4] = 1'b0;
         wr(OFF_LANE_MODE, d);
         rd(OFF_LANE_MODE);
         `CHK_EQ(r1, d & 8'h17)
         `CHK_EQ(r2, d & 8'h07)
         `CHK_EQ(mode, lanes(d))
         `CHK_EQ(mode2, lanes(d & 8'h07))
         `CHK_EQ(b64, d[1] & ~d[4])
         `CHK_EQ(byte_order_sel, d[0])
         `CHK_EQ(confl, 1'b0)
      end
      // Illegal split plus width: split must still win
      wr(OFF_LANE_MODE, 8'h12);
      #1 `CHK_EQ(mode, 3'b100)
      `CHK_EQ(confl, 1'b1)
      // ----------------------------------------
      // Ready thresholds at and around the edge
      // ----------------------------------------
      for (int i = 0; i < 40; i++) begin
         lt  = (i < 15) ? 4'(i + 1) : 4'h1 + 4'($urandom_range(14));
         lr  = (i < 15) ? 4'(15 - i) : 4'h1 + 4'($urandom_range(14));
         off = 1'($urandom_range(1));
         wr(OFF_LEVELS, {lt, lr});
         wr(OFF_LANE_MODE, {5'h00, off, 2'b00});
         @(posedge clk);
         load <= 1'b1;
         free <= (i % 4 == 3) ? 9'($urandom_range(256))
                              : thr(lt) - 9'($urandom_range(1));
         fill <= thr(lr) - 9'($urandom_range(1));
         hdr  <= 1'($urandom_range(1));
         @(posedge clk);
         load <= 1'b0;
         @(posedge clk);
         #1 `CHK_EQ(tx_rdy, tx_free >= thr(lt))
         `CHK_EQ(rx_rdy, (rx_fill >= thr(lr)) | (hdr & ~off))
      end
      stop_test();
   end
endmodule : fifo_ready_lane_config_tb_top
